// ### logic/fes_suspend_ctrl.sv
/*
 * fes_suspend_ctrl: command gating, erase suspend/resume sequencing and
 * status flags of a serial flash, with an APB register window.
 * Assumes a serial front end on the same clock that hands over one decoded
 * command per chip-select frame, with its full 32-bit address, and an
 * array engine that runs while its run level is high and pulses done.
 */
// Design decisions made here: the address map and the APB register port.

// Overview of operation
// - erase suspend is taken only while a sector erase runs.
// - erase suspend during a whole-array erase is ignored.
// - suspend halts the erase and updates flags within the latency limit.
// - while suspend is pending only the two status reads are taken.
// - busy flag clears when erase has stopped; host polls it.
// - erase-suspended flag sets on suspend, stays clear if erase finished.
// - erase resume is a no-op unless an erase is suspended.
// - reads inside the suspended sector return undefined data.
// - modifying commands need write enable latch set, else rejected.
// - register write and protection erase refused in erase suspend.
// - register write right after bank access loads the bank register.
// - program into the suspended sector fails and sets program error.
// - program inside erase suspend returns to erase suspend when done.
// - erase resume while suspended sets busy and continues the erase.
// - further resume commands after a resume are ignored.
// - fast and double-rate fast reads taken in both suspend states.
// - bank register read and write taken in both suspend states.
// - page and quad page program taken only in erase suspend.
// - program suspend taken during erase suspend, nesting the program.
// - program resume taken in both suspend states, incl nested.
// - dynamic protection read and write taken only in erase suspend.
// - clear status taken in erase suspend, not in program suspend.
// - persistent protection read taken only in erase suspend.
// - mode bit reset taken in both suspend states.
// - software reset taken at any time except while suspend is pending.
// - write enable taken in erase suspend, not in program suspend.
module fes_suspend_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoded command from serial front end
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [31:0] cmdAddr,
    input wire logic [7:0] cmdData,
    // command verdict
    output logic cmdAccept,
    output logic cmdReject,
    output logic readUndefined,
    // array engine
    input wire logic eraseDone,
    input wire logic progDone,
    input wire logic progFail,
    output logic eraseRun,
    output logic bulkErase,
    output logic [fes_pkg::SECT_W-1:0] eraseSector,
    output logic progRun,
    output logic [31:0] progAddr,
    // status registers
    output logic [7:0] statusOne,
    output logic [7:0] statusTwo,
    output logic [7:0] bankReg
);
    import fes_pkg::*;

    typedef struct packed {
        fes_op_t op;
        logic [11:0] cnt;
        logic [12:0] waitCnt;
        logic busy;
        logic wel;
        logic perr;
        logic bankPend;
        logic [7:0] bank;
        logic [SECT_W-1:0] eraseSec;
        logic [31:0] progAddr;
        logic [31:0] apbAddr;
        logic acc;
        logic rej;
        logic undef;
    } fes_state_t;

    fes_state_t q;
    fes_state_t d;
    fes_op_t cur;
    logic ok;
    logic apbCmd;
    logic cv;
    logic [7:0] code;
    logic [31:0] addr;
    logic [7:0] data;
    logic [SECT_W-1:0] sector;
    logic apbWr;
    logic esActive;

    // ************************************************************
    // opcode classes
    // ************************************************************
    function automatic logic isRead(input logic [7:0] c);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 15; i++) begin
            if (c == READ_CODES[i]) r = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            if (c == FAST_READ_CODES[i]) r = 1'b1;
        end
        return r;
    endfunction : isRead

    function automatic logic isProg(input logic [7:0] c);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (c == PROG_CODES[i]) r = 1'b1;
        end
        return r;
    endfunction : isProg

    function automatic logic isStat(input logic [7:0] c);
        return c == CMD_READ_STATUS_ONE || c == CMD_READ_STATUS_TWO;
    endfunction : isStat

    // allowed while the erase is suspended
    function automatic logic esAllowed(input logic [7:0] c);
        return isStat(c) || isRead(c) || isProg(c)
            || c == CMD_BANK_ACCESS || c == CMD_BANK_READ || c == CMD_BANK_WRITE
            || c == CMD_CLEAR_STATUS
            || c == CMD_DYN_PROT_READ || c == CMD_DYN_PROT_WRITE
            || c == CMD_PERS_PROT_READ
            || c == CMD_ERASE_RESUME || c == CMD_PROGRAM_SUSPEND
            || c == CMD_PROGRAM_RESUME
            || c == CMD_MODE_BIT_RESET
            || c == CMD_SOFT_RESET
            || c == CMD_WRITE_ENABLE
            || c == CMD_REGISTER_WRITE;
    endfunction : esAllowed

    // allowed while a program is suspended
    function automatic logic psAllowed(input logic [7:0] c);
        return isStat(c) || isRead(c)
            || c == CMD_BANK_ACCESS || c == CMD_BANK_READ || c == CMD_BANK_WRITE
            || c == CMD_PROGRAM_RESUME
            || c == CMD_MODE_BIT_RESET
            || c == CMD_SOFT_RESET;
    endfunction : psAllowed

    // commands that alter non-volatile content
    function automatic logic needsWel(input logic [7:0] c);
        return isProg(c) || c == CMD_SECTOR_ERASE || c == CMD_SECTOR_ERASE_WIDE
            || c == CMD_BULK_ERASE || c == CMD_BULK_ERASE_ALT
            || c == CMD_REGISTER_WRITE || c == CMD_DYN_PROT_WRITE;
    endfunction : needsWel

    // ************************************************************
    // apb slave
    // ************************************************************
    // command register write issues a command; port command takes priority
    assign apbWr = psel && penable && pwrite && pready;
    assign pready = !(psel && pwrite && paddr == OFF_CMD && cmdValid);
    assign apbCmd = apbWr && paddr == OFF_CMD;
    assign pslverr = psel && penable && !(paddr == OFF_STATUS || paddr == OFF_CMD
        || paddr == OFF_ADDR || paddr == OFF_SECTOR || paddr == OFF_BANK);

    // read mux over registered state
    always_comb begin
        unique case (paddr)
            OFF_STATUS: prdata = {16'h0000, statusTwo, statusOne};
            OFF_ADDR: prdata = q.apbAddr;
            OFF_SECTOR: prdata = {18'h00000, q.eraseSec};
            OFF_BANK: prdata = {24'h000000, q.bank};
            default: prdata = 32'h00000000;
        endcase
    end

    // ************************************************************
    // command source merge
    // ************************************************************
    assign cv = cmdValid || apbCmd;
    assign code = cmdValid ? cmdCode : pwdata[7:0];
    assign addr = cmdValid ? cmdAddr : q.apbAddr;
    assign data = cmdValid ? cmdData : pwdata[15:8];
    assign sector = addr[SECT_LSB +: SECT_W];

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        d = q;
        d.acc = 1'b0;
        d.rej = 1'b0;
        d.undef = 1'b0;
        ok = 1'b0;
        if (apbWr && paddr == OFF_ADDR) begin
            d.apbAddr = pwdata;
        end
        // engine events come first; commands see the result
        unique case (q.op)
            OP_SE_RUN, OP_BE_RUN, OP_SE_SUSPENDING: begin
                if (eraseDone) begin
                    d.op = OP_IDLE; // finished before suspend took effect
                    d.busy = 1'b0;
                end else if (q.op == OP_SE_SUSPENDING) begin
                    if (q.cnt == 12'h000) begin
                        d.op = OP_ES_IDLE;
                        d.busy = 1'b0;
                    end else begin
                        d.cnt = q.cnt - 12'h001;
                    end
                end
            end
            OP_PG_RUN, OP_ES_PROG: begin
                if (progDone) begin
                    d.busy = 1'b0;
                    d.perr = q.perr | progFail;
                    d.op = (q.op == OP_ES_PROG) ? OP_ES_IDLE : OP_IDLE;
                end
            end
            OP_IDLE, OP_ES_IDLE, OP_ES_PGSUSP, OP_PG_SUSP: begin
            end
        endcase
        cur = d.op;
        esActive = cur == OP_ES_IDLE || cur == OP_ES_PROG || cur == OP_ES_PGSUSP;
        // gating per state
        if (cv) begin
            unique case (cur)
                OP_IDLE: ok = !(code == CMD_ERASE_SUSPEND || code == CMD_ERASE_RESUME
                    || code == CMD_PROGRAM_SUSPEND || code == CMD_PROGRAM_RESUME);
                OP_SE_SUSPENDING: ok = isStat(code);
                OP_SE_RUN: ok = isStat(code) || code == CMD_SOFT_RESET
                    || code == CMD_ERASE_SUSPEND;
                OP_BE_RUN: ok = isStat(code) || code == CMD_SOFT_RESET;
                OP_PG_RUN, OP_ES_PROG: ok = isStat(code) || code == CMD_SOFT_RESET
                    || code == CMD_PROGRAM_SUSPEND;
                OP_ES_IDLE: ok = esAllowed(code);
                OP_PG_SUSP, OP_ES_PGSUSP: ok = psAllowed(code);
            endcase
            if (code == CMD_REGISTER_WRITE && cur == OP_ES_IDLE && !q.bankPend) begin
                ok = 1'b0;
            end
            if (needsWel(code) && !q.wel && !(code == CMD_REGISTER_WRITE && q.bankPend)) begin
                ok = 1'b0;
            end
        end
        d.acc = cv && ok;
        d.rej = cv && !ok;
        // effects of an accepted command
        if (cv && ok) begin
            d.bankPend = code == CMD_BANK_ACCESS;
            if (needsWel(code) && !(code == CMD_REGISTER_WRITE && q.bankPend)) begin
                d.wel = 1'b0;
            end
            if (code == CMD_WRITE_ENABLE) begin
                d.wel = 1'b1;
            end
            if (code == CMD_SOFT_RESET) begin
                d.wel = 1'b0;
            end
            if (code == CMD_CLEAR_STATUS) begin
                d.perr = progDone && progFail; // a fresh failure wins
            end
            if (code == CMD_BANK_WRITE || (code == CMD_REGISTER_WRITE && q.bankPend)) begin
                d.bank = data;
            end
            if (isRead(code) && esActive && sector == q.eraseSec) begin
                d.undef = 1'b1;
            end
            if (code == CMD_ERASE_SUSPEND) begin
                d.op = OP_SE_SUSPENDING;
                d.cnt = ESL_LOAD;
            end
            if (code == CMD_ERASE_RESUME) begin
                d.op = OP_SE_RUN;
                d.busy = 1'b1;
            end
            if (code == CMD_PROGRAM_SUSPEND && cur != OP_ES_IDLE) begin
                d.op = (cur == OP_ES_PROG) ? OP_ES_PGSUSP : OP_PG_SUSP;
                d.busy = 1'b0;
            end
            if (code == CMD_PROGRAM_RESUME && cur != OP_ES_IDLE) begin
                d.op = (cur == OP_ES_PGSUSP) ? OP_ES_PROG : OP_PG_RUN;
                d.busy = 1'b1;
            end
            if (isProg(code)) begin
                if (cur == OP_ES_IDLE && sector == q.eraseSec) begin
                    d.perr = 1'b1;
                end else begin
                    d.op = (cur == OP_ES_IDLE) ? OP_ES_PROG : OP_PG_RUN;
                    d.busy = 1'b1;
                    d.progAddr = addr;
                end
            end
            if (code == CMD_SECTOR_ERASE || code == CMD_SECTOR_ERASE_WIDE) begin
                d.op = OP_SE_RUN;
                d.busy = 1'b1;
                d.eraseSec = sector;
            end
            if (code == CMD_BULK_ERASE || code == CMD_BULK_ERASE_ALT) begin
                d.op = OP_BE_RUN;
                d.busy = 1'b1;
            end
        end
        // cycles spent waiting for suspend to take effect
        d.waitCnt = (d.op == OP_SE_SUSPENDING) ? q.waitCnt + 13'h0001 : 13'h0000;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.bank <= RST_BANK;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign cmdAccept = q.acc;
    assign cmdReject = q.rej;
    assign readUndefined = q.undef;
    assign eraseRun = q.op == OP_SE_RUN || q.op == OP_BE_RUN || q.op == OP_SE_SUSPENDING;
    assign bulkErase = q.op == OP_BE_RUN;
    assign eraseSector = q.eraseSec;
    assign progRun = q.op == OP_PG_RUN || q.op == OP_ES_PROG;
    assign progAddr = q.progAddr;
    assign bankReg = q.bank;

    // status register images
    always_comb begin
        statusOne = 8'h00;
        statusOne[ST1_BUSY_BIT] = q.busy;
        statusOne[ST1_WEL_BIT] = q.wel;
        statusOne[ST1_PERR_BIT] = q.perr;
        statusTwo = 8'h00;
        statusTwo[ST2_ESUS_BIT] = q.op == OP_ES_IDLE || q.op == OP_ES_PROG
            || q.op == OP_ES_PGSUSP;
        statusTwo[ST2_PSUS_BIT] = q.op == OP_PG_SUSP || q.op == OP_ES_PGSUSP;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    susp_entry_a: assert property (
        cv && code == CMD_ERASE_SUSPEND && q.op == OP_SE_RUN && !eraseDone
        |=> q.op == OP_SE_SUSPENDING && cmdAccept)
        else $error("erase suspend not taken during sector erase");
    bulk_ignore_a: assert property (
        cv && code == CMD_ERASE_SUSPEND && q.op == OP_BE_RUN && !eraseDone
        |=> cmdReject && q.op == OP_BE_RUN)
        else $error("erase suspend acted during bulk erase");
    susp_latency_a: assert property (
        q.waitCnt <= 13'(ESL_CYC))
        else $error("erase suspend latency exceeded");
    pending_gate_a: assert property (
        cv && q.op == OP_SE_SUSPENDING && |q.cnt && !eraseDone && !isStat(code) |=> cmdReject)
        else $error("command taken while suspend pending");
    busy_clear_a: assert property (
        $fell(q.op == OP_SE_SUSPENDING) |-> !statusOne[ST1_BUSY_BIT])
        else $error("busy flag still set after erase stopped");
    esus_flag_a: assert property (
        q.op == OP_SE_SUSPENDING && q.cnt == 12'h000 && !eraseDone
        |=> statusTwo[ST2_ESUS_BIT] ##1 statusTwo[ST2_ESUS_BIT] || statusOne[ST1_BUSY_BIT])
        else $error("erase suspended flag not set");
    done_no_esus_a: assert property (
        q.op == OP_SE_SUSPENDING && eraseDone |=> !statusTwo[ST2_ESUS_BIT] && !eraseRun)
        else $error("suspended flag set after erase finished");
    resume_run_a: assert property (
        cv && code == CMD_ERASE_RESUME && q.op == OP_ES_IDLE
        |=> statusOne[ST1_BUSY_BIT] && eraseRun)
        else $error("erase resume did not restart erase");
    sector_fail_a: assert property (
        cv && isProg(code) && q.op == OP_ES_IDLE && q.wel && sector == q.eraseSec
        |=> statusOne[ST1_PERR_BIT] && q.op == OP_ES_IDLE && !progRun)
        else $error("program into suspended sector not failed");
    nested_back_a: assert property (
        q.op == OP_ES_PROG && progDone && !cv |=> q.op == OP_ES_IDLE && !statusOne[ST1_BUSY_BIT])
        else $error("program in erase suspend did not return");
    reg_refuse_a: assert property (
        cv && code == CMD_REGISTER_WRITE && q.op == OP_ES_IDLE && !q.bankPend
        |=> cmdReject && $stable(bankReg))
        else $error("register write taken in erase suspend");

    susp_reached_c: cover property (
        q.op == OP_SE_SUSPENDING ##1 q.op == OP_ES_IDLE);
    resume_c: cover property (q.op == OP_ES_IDLE ##1 q.op == OP_SE_RUN);
    nested_c: cover property (q.op == OP_ES_PGSUSP ##1 q.op == OP_ES_PROG);
    perr_c: cover property (q.op == OP_ES_IDLE && $rose(statusOne[ST1_PERR_BIT]));

endmodule : fes_suspend_ctrl

// ### logic/fes_pkg.sv
/*
 * fes_pkg: constants, opcodes, register map and state encoding for the
 * flash erase suspend/resume controller.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
package fes_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_SUSPEND_LATENCY_NS = 40000;
    // longest time, so rounded down
    localparam int ESL_CYC = ERASE_SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
    localparam logic [11:0] ESL_LOAD = 12'(ESL_CYC - 1);

    // ************************************************************
    // geometry, status bits and reset values
    // ************************************************************
    localparam int SECT_LSB = 18;
    localparam int SECT_W = 14;
    localparam int ST1_BUSY_BIT = 0;
    localparam int ST1_WEL_BIT = 1;
    localparam int ST1_PERR_BIT = 6;
    localparam int ST2_PSUS_BIT = 0;
    localparam int ST2_ESUS_BIT = 1;
    localparam logic [7:0] RST_BANK = 8'h00;

    // ************************************************************
    // apb register offsets
    // ************************************************************
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_SECTOR = 8'h0C;
    localparam logic [7:0] OFF_BANK = 8'h10;

    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [7:0] CMD_READ_STATUS_ONE = 8'h05, CMD_READ_STATUS_TWO = 8'h07;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06, CMD_REGISTER_WRITE = 8'h01;
    localparam logic [7:0] CMD_BANK_ACCESS = 8'hB9, CMD_BANK_READ = 8'h16;
    localparam logic [7:0] CMD_BANK_WRITE = 8'h17, CMD_CLEAR_STATUS = 8'h30;
    localparam logic [7:0] CMD_DYN_PROT_READ = 8'hE0, CMD_DYN_PROT_WRITE = 8'hE1;
    localparam logic [7:0] CMD_PERS_PROT_READ = 8'hE2, CMD_MODE_BIT_RESET = 8'hFF;
    localparam logic [7:0] CMD_ERASE_SUSPEND = 8'h75, CMD_ERASE_RESUME = 8'h7A;
    localparam logic [7:0] CMD_PROGRAM_SUSPEND = 8'h85, CMD_PROGRAM_RESUME = 8'h8A;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hF0, CMD_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] CMD_SECTOR_ERASE_WIDE = 8'hDC, CMD_BULK_ERASE = 8'h60;
    localparam logic [7:0] CMD_BULK_ERASE_ALT = 8'hC7;
    localparam logic [7:0] FAST_READ_CODES [4] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E};
    localparam logic [7:0] PROG_CODES [5] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34};
    localparam logic [7:0] READ_CODES [15] = '{8'h03, 8'h13, 8'h35, 8'hBB, 8'hBC,
        8'h3B, 8'h3C, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'hEB, 8'hEC, 8'h6B, 8'h6C};

    // ************************************************************
    // operation state
    // ************************************************************
    typedef enum logic [3:0] {
        OP_IDLE, OP_SE_RUN, OP_BE_RUN, OP_SE_SUSPENDING, OP_ES_IDLE,
        OP_ES_PROG, OP_ES_PGSUSP, OP_PG_RUN, OP_PG_SUSP
    } fes_op_t;

endpackage : fes_pkg

// ### verif/fes_engine_model.sv
/* fes_engine_model: behavioural array engine behind the suspend controller.
   Assumes the controller's clock and its erase and program run levels. */
module fes_engine_model #(
    parameter int ERASE_LEN = 6000,
    parameter int PROG_LEN = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // run levels and done pulses
    input wire logic eraseRun,
    input wire logic progRun,
    output logic eraseDone,
    output logic progDone,
    output logic progFail
);
    timeunit 1ns;
    timeprecision 1ps;
    int eraseCnt;
    int progCnt;
    // progress is kept while halted, so a resume continues
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eraseCnt <= 0;
            progCnt <= 0;
        end else begin
            eraseCnt <= eraseDone ? 0 : eraseCnt + int'(eraseRun);
            progCnt <= progDone ? 0 : progCnt + int'(progRun);
        end
    end
    assign eraseDone = eraseRun && eraseCnt == ERASE_LEN - 1;
    assign progDone = progRun && progCnt == PROG_LEN - 1;
    assign progFail = 1'b0; // programs never fail here
endmodule : fes_engine_model

// ### verif/tb.sv
/* tb: self-checking bench for fes_suspend_ctrl.
   Assumes the engine model and commands driven on the command port and the APB command register. */
module tb import fes_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SA = 32'h0004_0000, SB = 32'h0008_0000;
    localparam logic [7:0] ES_OK [6] = '{8'h16, 8'h17, 8'hFF, 8'hF0, 8'hE0, 8'hE2};
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, cmdValid = 0;
    logic [7:0] paddr = 0, cmdCode = 0, cmdData = 0, statusOne, statusTwo, bankReg;
    logic [31:0] pwdata = 0, cmdAddr = 0, prdata, progAddr, rd;
    logic pready, pslverr, cmdAccept, cmdReject, readUndefined, er;
    logic eraseDone, progDone, progFail, eraseRun, bulkErase, progRun;
    logic [SECT_W-1:0] eraseSector;
    int n_mismatch = 0, checks_done = 0;
    fes_suspend_ctrl u_fes_suspend_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdAccept(cmdAccept),
        .cmdReject(cmdReject), .readUndefined(readUndefined), .eraseDone(eraseDone),
        .progDone(progDone), .progFail(progFail), .eraseRun(eraseRun),
        .bulkErase(bulkErase), .eraseSector(eraseSector), .progRun(progRun),
        .progAddr(progAddr), .statusOne(statusOne), .statusTwo(statusTwo),
        .bankReg(bankReg));
    fes_engine_model u_fes_engine_model (.clk(clk), .rst_n(rst_n), .eraseRun(eraseRun),
        .progRun(progRun), .eraseDone(eraseDone), .progDone(progDone),
        .progFail(progFail));
    // ************************************************************
    // clock and shared tasks
    // ************************************************************
    always #5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one command frame, verdict judged one cycle later
    task automatic cmd(input logic [7:0] c, input logic [31:0] a, input logic [7:0] d,
        input logic acc);
        @(posedge clk);
        cmdValid <= 1;
        cmdCode <= c;
        cmdAddr <= a;
        cmdData <= d;
        @(posedge clk);
        cmdValid <= 0;
        #1 chk({cmdAccept, cmdReject}, {acc, !acc});
    endtask : cmd
    // apb transfer held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic waitIdle(input int lim);
        int i;
        for (i = 0; i < lim && statusOne[0] !== 1'b0; i++) @(posedge clk);
        #1 chk(i < lim, 1);
    endtask : waitIdle
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic tSuspend();
        cmd(CMD_WRITE_ENABLE, 0, 0, 1);
        cmd(CMD_SECTOR_ERASE, SA, 0, 1);
        chk(eraseSector, 1);
        cmd(CMD_ERASE_SUSPEND, SA, 0, 1);
        cmd(FAST_READ_CODES[0], SB, 0, 0);
        cmd(CMD_READ_STATUS_TWO, 0, 0, 1);
        chk(statusOne[0], 1);
        waitIdle(ESL_CYC + 2);
        chk(eraseRun, 0);
        apb(0, OFF_STATUS, 0);
        chk(rd, 32'h0000_0200);
        apb(0, 8'h40, 0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        $display("suspend test done");
    endtask : tSuspend
    task automatic tInside();
        cmd(PROG_CODES[0], SB, 0, 0);
        cmd(CMD_WRITE_ENABLE, 0, 0, 1);
        cmd(PROG_CODES[0], SA, 0, 1);
        chk(statusOne[ST1_PERR_BIT], 1);
        cmd(CMD_CLEAR_STATUS, 0, 0, 1);
        chk(statusOne, 0);
        cmd(FAST_READ_CODES[2], SA, 0, 1);
        chk(readUndefined, 1);
        foreach (ES_OK[i]) cmd(ES_OK[i], SB, 0, 1);
        cmd(CMD_WRITE_ENABLE, 0, 0, 1);
        cmd(CMD_SECTOR_ERASE, SB, 0, 0);
        cmd(CMD_REGISTER_WRITE, 0, 8'h5A, 0);
        cmd(CMD_BANK_ACCESS, 0, 0, 1);
        cmd(CMD_REGISTER_WRITE, 0, 8'h5A, 1);
        chk(bankReg, 8'h5A);
        cmd(CMD_WRITE_ENABLE, 0, 0, 1);
        cmd(PROG_CODES[4], SB, 0, 1);
        chk(progRun, 1);
        chk(progAddr, SB);
        cmd(CMD_PROGRAM_SUSPEND, 0, 0, 1);
        chk(statusTwo, 8'h03);
        cmd(CMD_PROGRAM_RESUME, 0, 0, 1);
        waitIdle(50);
        chk(statusTwo, 8'h02);
        $display("inside test done");
    endtask : tInside
    task automatic tResume();
        apb(1, OFF_CMD, {24'h0, CMD_ERASE_RESUME});
        #1 chk(cmdAccept, 1);
        chk({statusOne[0], statusTwo}, 9'h100);
        cmd(CMD_ERASE_RESUME, 0, 0, 0);
        waitIdle(3000);
        cmd(CMD_ERASE_RESUME, 0, 0, 0);
        $display("resume test done");
    endtask : tResume
    task automatic tBulk();
        cmd(CMD_WRITE_ENABLE, 0, 0, 1);
        cmd(CMD_BULK_ERASE, 0, 0, 1);
        chk(bulkErase, 1);
        cmd(CMD_ERASE_SUSPEND, 0, 0, 0);
        cmd(CMD_ERASE_RESUME, 0, 0, 0);
        waitIdle(7000);
        chk(statusTwo, 0);
        $display("bulk test done");
    endtask : tBulk
    // erase finishes while the suspend is still pending
    task automatic tLate();
        cmd(CMD_WRITE_ENABLE, 0, 0, 1);
        cmd(CMD_SECTOR_ERASE, SB, 0, 1);
        repeat (2500) @(posedge clk);
        cmd(CMD_ERASE_SUSPEND, SB, 0, 1);
        waitIdle(ESL_CYC + 2);
        chk({eraseRun, statusTwo}, 0);
        cmd(CMD_ERASE_RESUME, 0, 0, 0);
        $display("late suspend test done");
    endtask : tLate
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        tSuspend();
        tInside();
        tResume();
        tBulk();
        tLate();
        results();
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule : tb
